//--- dct_display_cache_timing.sv
// Function
// - control registers sit at base plus offset; every memory access is answered at any offset, no other space is
// - row-kind bit 0 tells whether a 4 MB display cache is fitted
// - bit 4 chooses page-open (0) or page-close (1) policy
// - override bit 3 forces activate-to-command delay to 2 clocks
// - latency bit 2 gives CAS latency and delay 2/2 or 3/3
// - bit 1 gives active-to-precharge and cycle time 5/8 or 7/10
// - bit 0 gives precharge time 2 or 3 clocks
`timescale 1ns/1ns
`default_nettype none
module dct_display_cache_timing (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [31:0] mmioBase,
  input wire dct_pkg::dct_req_t memReq,
  output logic memAck,
  output logic [7:0] memRdata,
  input wire logic cmdValid,
  input wire dct_pkg::dct_cmd_t cmdKind,
  output logic [3:0] cmdReady,
  output logic cmdIssue,
  output dct_pkg::dct_cmd_t cmdIssueKind,
  output logic cmdAutoPrecharge,
  output logic cachePopulated,
  output logic pageClosePolicy,
  output dct_pkg::dct_timing_t timing
);
  import dct_pkg::*;

  // pick the long or short figure of a timing field
  function automatic logic [3:0] pickTime(input logic sel, input logic [3:0] lo,
                                          input logic [3:0] hi);
    pickTime = sel ? hi : lo;
  endfunction

  // saturating cycle count since an event
  function automatic logic [3:0] ageUp(input logic [3:0] age);
    ageUp = (age == SINCE_MAX) ? SINCE_MAX : age + 4'h1;
  endfunction

  logic [7:0] rowKind;
  logic [7:0] timingCtl;
  logic [3:0] sinceAct;
  logic [3:0] sincePre;
  logic [3:0] sinceRef;
  logic rowOpen;

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  wire logic memAccess = memReq.valid && (memReq.space == SPACE_MEM);
  wire logic hitRowKind = memReq.addr == mmioBase + OFS_ROW_KIND;
  wire logic hitTimingCtl = memReq.addr == mmioBase + OFS_TIMING_CTL;
  wire logic writeRowKind = memAccess && memReq.write && hitRowKind;
  wire logic writeTimingCtl = memAccess && memReq.write && hitTimingCtl;
  logic [7:0] readData;

  // unmapped memory offsets answer with zero
  always_comb begin
    if (hitRowKind) begin
      readData = rowKind;
    end else if (hitTimingCtl) begin
      readData = timingCtl;
    end else begin
      readData = 8'h00;
    end
  end

  wire logic [7:0] next_rowKind = writeRowKind ? (memReq.wdata & MASK_ROW_KIND) : rowKind;
  wire logic [7:0] next_timingCtl =
    writeTimingCtl ? (memReq.wdata & MASK_TIMING_CTL) : timingCtl;

  // register file and bus answer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rowKind <= RST_ROW_KIND;
      timingCtl <= RST_TIMING_CTL;
      memAck <= 1'b0;
      memRdata <= 8'h00;
    end else begin
      rowKind <= next_rowKind;
      timingCtl <= next_timingCtl;
      memAck <= memAccess;
      memRdata <= (memAccess && !memReq.write) ? readData : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing decode, taken from the freshly written value so a command after
  // the write acknowledge already sees it

  wire logic latLong = next_timingCtl[BIT_COLUMN_STROBE_LATENCY];
  dct_timing_t next_timing;

  always_comb begin
    next_timing.cas = pickTime(latLong, CL_SHORT, CL_LONG);
    next_timing.rcd = next_timingCtl[BIT_ROW_TO_COLUMN_OVERRIDE] ? RCD_OVERRIDE
                      : pickTime(latLong, CL_SHORT, CL_LONG);
    next_timing.ras = pickTime(next_timingCtl[BIT_ROW_ACTIVE_TIME], RAS_SHORT, RAS_LONG);
    next_timing.rc = pickTime(next_timingCtl[BIT_ROW_ACTIVE_TIME], RC_SHORT, RC_LONG);
    next_timing.rp = pickTime(next_timingCtl[BIT_ROW_PRECHARGE_TIME], RP_SHORT, RP_LONG);
  end

  // presence and policy straight from flops
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timing <= '{cas: CL_LONG, rcd: CL_LONG, ras: RAS_LONG, rc: RC_LONG, rp: RP_LONG};
      cachePopulated <= 1'b0;
      pageClosePolicy <= 1'b1;
    end else begin
      timing <= next_timing;
      cachePopulated <= next_rowKind[BIT_CACHE_POPULATED];
      pageClosePolicy <= next_timingCtl[BIT_PAGE_POLICY];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command spacing: one bank, counters age every clock and saturate

  wire logic take = cmdValid && cmdReady[cmdKind];
  // a closed-page access restarts both ages here, so readiness sees it at once
  wire logic closeRw = take && cmdKind == CMD_RW && pageClosePolicy;
  wire logic [3:0] next_sinceAct =
    ((take && cmdKind == CMD_ACT) || closeRw) ? 4'h1 : ageUp(sinceAct);
  wire logic [3:0] next_sincePre =
    ((take && cmdKind == CMD_PRE) || closeRw) ? 4'h1 : ageUp(sincePre);
  wire logic [3:0] next_sinceRef = (take && cmdKind == CMD_REF) ? 4'h1 : ageUp(sinceRef);
  logic next_rowOpen;
  logic [3:0] next_ready;

  // row state follows activate and precharge
  always_comb begin
    next_rowOpen = rowOpen;
    if (take && cmdKind == CMD_ACT) begin
      next_rowOpen = 1'b1;
    end else if (take && cmdKind == CMD_PRE) begin
      next_rowOpen = 1'b0;
    end else if (take && cmdKind == CMD_RW && pageClosePolicy) begin
      next_rowOpen = 1'b0;
    end
  end

  always_comb begin
    next_ready[CMD_ACT] = !next_rowOpen && next_sincePre >= next_timing.rp
                          && next_sinceAct >= next_timing.rc
                          && next_sinceRef >= next_timing.rc;
    next_ready[CMD_RW] = next_rowOpen && next_sinceAct >= next_timing.rcd;
    next_ready[CMD_PRE] = next_rowOpen && next_sinceAct >= next_timing.ras;
    next_ready[CMD_REF] = !next_rowOpen && next_sincePre >= next_timing.rp
                          && next_sinceRef >= next_timing.rc;
  end

  // a closed-page access carries its own precharge, so that row-close
  // costs no separate command slot
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sinceAct <= SINCE_MAX;
      sincePre <= SINCE_MAX;
      sinceRef <= SINCE_MAX;
      rowOpen <= 1'b0;
      cmdReady <= 4'h0;
      cmdIssue <= 1'b0;
      cmdIssueKind <= CMD_ACT;
      cmdAutoPrecharge <= 1'b0;
    end else begin
      sinceAct <= next_sinceAct;
      sincePre <= next_sincePre;
      sinceRef <= next_sinceRef;
      rowOpen <= next_rowOpen;
      cmdReady <= next_ready;
      cmdIssue <= take;
      cmdIssueKind <= cmdKind;
      cmdAutoPrecharge <= closeRw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_mem_only;
    @(posedge sys_clk) disable iff (reset)
      (memReq.valid && memReq.space != SPACE_MEM) |=> !memAck;
  endproperty
  a_mem_only: assert property (p_mem_only) else $error("non-memory access answered");

  property p_mem_ack;
    @(posedge sys_clk) disable iff (reset) memAccess |=> memAck;
  endproperty
  a_mem_ack: assert property (p_mem_ack) else $error("memory access not answered");

  property p_populated;
    @(posedge sys_clk) disable iff (reset)
      writeRowKind |=> cachePopulated == $past(memReq.wdata[0]) ##1 rowKind[0] == cachePopulated;
  endproperty
  a_populated: assert property (p_populated) else $error("presence bit not taken");

  property p_close_auto;
    @(posedge sys_clk) disable iff (reset)
      (take && cmdKind == CMD_RW && pageClosePolicy) |=> cmdAutoPrecharge && !rowOpen;
  endproperty
  a_close_auto: assert property (p_close_auto) else $error("close policy kept row open");

  property p_rcd;
    @(posedge sys_clk) disable iff (reset)
      timing.rcd == (timingCtl[BIT_ROW_TO_COLUMN_OVERRIDE] ? 4'h2 : (timingCtl[2] ? 4'h3 : 4'h2));
  endproperty
  a_rcd: assert property (p_rcd) else $error("row-to-column delay wrong");

  property p_cas;
    @(posedge sys_clk) disable iff (reset)
      writeTimingCtl |=> timing.cas == ($past(memReq.wdata[2]) ? 4'h3 : 4'h2);
  endproperty
  a_cas: assert property (p_cas) else $error("latency not applied");

  property p_ras;
    @(posedge sys_clk) disable iff (reset)
      (take && cmdKind == CMD_PRE) |-> sinceAct >= (timingCtl[1] ? 4'h7 : 4'h5);
  endproperty
  a_ras: assert property (p_ras) else $error("precharge too early");

  property p_rp;
    @(posedge sys_clk) disable iff (reset)
      (take && cmdKind == CMD_ACT) |-> sincePre >= (timingCtl[0] ? 4'h3 : 4'h2);
  endproperty
  a_rp: assert property (p_rp) else $error("activate too soon after precharge");

  property p_reserved;
    @(posedge sys_clk) disable iff (reset) memAck |-> memRdata[7:5] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_rw_space;
    @(posedge sys_clk) disable iff (reset)
      (take && cmdKind == CMD_RW) |-> rowOpen && sinceAct >= timing.rcd;
  endproperty
  a_rw_space: assert property (p_rw_space) else $error("access before row ready");

endmodule
`default_nettype wire

//--- dct_pkg.sv
`default_nettype none
package dct_pkg;

  // register offsets from the memory-mapped base
  localparam logic [31:0] OFS_ROW_KIND = 32'h0000_3000;
  localparam logic [31:0] OFS_TIMING_CTL = 32'h0000_3001;

  // reset values
  localparam logic [7:0] RST_ROW_KIND = 8'h00;
  localparam logic [7:0] RST_TIMING_CTL = 8'h17;

  // writable bit masks, the rest reads as zero
  localparam logic [7:0] MASK_ROW_KIND = 8'h01;
  localparam logic [7:0] MASK_TIMING_CTL = 8'h1f;

  // field positions
  localparam int BIT_CACHE_POPULATED = 0;
  localparam int BIT_PAGE_POLICY = 4;
  localparam int BIT_ROW_TO_COLUMN_OVERRIDE = 3;
  localparam int BIT_COLUMN_STROBE_LATENCY = 2;
  localparam int BIT_ROW_ACTIVE_TIME = 1;
  localparam int BIT_ROW_PRECHARGE_TIME = 0;

  // timing counts in local memory clocks
  localparam logic [3:0] CL_SHORT = 4'h2;
  localparam logic [3:0] CL_LONG = 4'h3;
  localparam logic [3:0] RCD_OVERRIDE = 4'h2;
  localparam logic [3:0] RAS_SHORT = 4'h5;
  localparam logic [3:0] RAS_LONG = 4'h7;
  localparam logic [3:0] RC_SHORT = 4'h8;
  localparam logic [3:0] RC_LONG = 4'ha;
  localparam logic [3:0] RP_SHORT = 4'h2;
  localparam logic [3:0] RP_LONG = 4'h3;
  localparam logic [3:0] SINCE_MAX = 4'hf;

  typedef enum logic [1:0] {SPACE_CONFIG, SPACE_IO, SPACE_MEM} dct_space_t;
  typedef enum logic [1:0] {CMD_ACT, CMD_RW, CMD_PRE, CMD_REF} dct_cmd_t;

  typedef struct packed {
    logic valid;
    logic write;
    dct_space_t space;
    logic [31:0] addr;
    logic [7:0] wdata;
  } dct_req_t;

  typedef struct packed {
    logic [3:0] cas;
    logic [3:0] rcd;
    logic [3:0] ras;
    logic [3:0] rc;
    logic [3:0] rp;
  } dct_timing_t;

endpackage
`default_nettype wire

//--- dct_sdram_model.sv
`timescale 1ns/1ns
`default_nettype none
module dct_sdram_model
  import dct_pkg::*;
(
  input wire logic sys_clk,
  input wire logic cmdIssue,
  input wire dct_pkg::dct_cmd_t cmdIssueKind,
  input wire logic cmdAutoPrecharge,
  input wire dct_pkg::dct_timing_t expTiming,
  output var int violations,
  output var int rwGap,
  output var logic rwAuto
);
  // clocks since the last activate, precharge and refresh
  int sAct = 99;
  int sPre = 99;
  int sRef = 99;
  // one driver for the count; the port just follows it
  int nViol = 0;
  assign violations = nViol;
  ////////////////////////////////////////////////////////////////////////
  // spacing per command
  always @(posedge sys_clk) begin
    sAct <= sAct + 1;
    sPre <= sPre + 1;
    sRef <= sRef + 1;
    if (cmdIssue === 1'b1) begin
      case (cmdIssueKind)
        CMD_ACT: begin
          if (sPre < expTiming.rp || sAct < expTiming.rc || sRef < expTiming.rc)
            nViol <= nViol + 1;
          sAct <= 1;
        end
        // auto-precharge closes the row, so it starts the precharge count
        CMD_RW: begin
          if (sAct < expTiming.rcd) nViol <= nViol + 1;
          rwGap <= sAct;
          rwAuto <= cmdAutoPrecharge;
          if (cmdAutoPrecharge) sPre <= 1;
        end
        CMD_PRE: begin
          if (sAct < expTiming.ras) nViol <= nViol + 1;
          sPre <= 1;
        end
        default: begin
          if (sPre < expTiming.rp || sRef < expTiming.rc) nViol <= nViol + 1;
          sRef <= 1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dct_pkg::*;
  logic sys_clk = 0, reset = 1, cmdValid = 0, memAck, cmdIssue, cmdAutoPrecharge;
  logic cachePopulated, pageClosePolicy, rwAuto;
  logic [31:0] mmioBase = 0;
  logic [7:0] memRdata, v;
  logic [3:0] cmdReady;
  dct_req_t memReq = '0;
  dct_cmd_t cmdKind = CMD_ACT, cmdIssueKind;
  dct_timing_t timing, expT;
  int err_count = 0, n_tests = 0, violations, rwGap;
  logic [7:0] q[$];

  dct_display_cache_timing u_dut(.sys_clk(sys_clk), .reset(reset), .mmioBase(mmioBase),
    .memReq(memReq), .memAck(memAck), .memRdata(memRdata), .cmdValid(cmdValid),
    .cmdKind(cmdKind), .cmdReady(cmdReady), .cmdIssue(cmdIssue),
    .cmdIssueKind(cmdIssueKind), .cmdAutoPrecharge(cmdAutoPrecharge),
    .cachePopulated(cachePopulated), .pageClosePolicy(pageClosePolicy), .timing(timing));
  dct_sdram_model u_mem(.sys_clk(sys_clk), .cmdIssue(cmdIssue), .cmdIssueKind(cmdIssueKind),
    .cmdAutoPrecharge(cmdAutoPrecharge), .expTiming(expT), .violations(violations),
    .rwGap(rwGap), .rwAuto(rwAuto));

  // clock, 10 ns period
  initial forever #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////
  // expected timing set for a control byte
  function automatic dct_timing_t texp(logic [7:0] c);
    logic [3:0] cl;
    cl = c[2] ? 4'h3 : 4'h2;
    return '{cl, c[3] ? 4'h2 : cl, c[1] ? 4'h7 : 4'h5, c[1] ? 4'ha : 4'h8, c[0] ? 4'h3 : 4'h2};
  endfunction
  task automatic chk(string nm, logic [19:0] e, logic [19:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one-cycle strobe; only memory space is expected to answer
  task automatic acc(dct_space_t sp, logic wr, logic [15:0] ofs, logic [7:0] wd, logic [7:0] e);
    memReq = '{1'b1, wr, sp, mmioBase + {16'h0, ofs}, wd};
    if (sp == SPACE_MEM) q.push_back(e);
    @(negedge sys_clk);
    memReq.valid = 0;
    @(negedge sys_clk);
  endtask
  // valid stays up into the next call so kinds follow back to back
  task automatic cmd(dct_cmd_t k);
    int n;
    cmdKind = k;
    cmdValid = 1;
    n = 0;
    while (cmdReady[k] !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    chk("ready", 1, n < 60);
    @(negedge sys_clk);
  endtask
  task automatic finish_test;
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // read data watcher, an ack with nothing pending is a fault
  always @(posedge sys_clk) begin
    if (memAck === 1'b1) begin
      if (q.size() == 0) chk("ack", 0, 1);
      else chk("rdata", q.pop_front(), memRdata);
    end
  end
  // watchdog
  initial begin
    #300000;
    err_count++;
    finish_test;
  end
  // main sequence
  initial begin
    void'($urandom(78917));
    mmioBase = $urandom() & 32'hfff0_0000;
    expT = texp(8'h17);
    repeat (8) @(negedge sys_clk);
    reset = 0;
    @(negedge sys_clk);
    chk("timing", texp(8'h17), timing);
    chk("flags", 2'b10, {pageClosePolicy, cachePopulated});
    acc(SPACE_MEM, 0, 16'h3000, 0, 8'h00);
    acc(SPACE_MEM, 0, 16'h3001, 0, 8'h17);
    acc(SPACE_MEM, 1, 16'h3000, 8'hff, 0);
    acc(SPACE_MEM, 0, 16'h3000, 0, 8'h01);
    chk("populated", 1, cachePopulated);
    // foreign spaces must leave the control byte alone
    acc(SPACE_CONFIG, 1, 16'h3001, 8'h00, 0);
    acc(SPACE_IO, 1, 16'h3001, 8'h00, 0);
    acc(SPACE_MEM, 0, 16'h3001, 0, 8'h17);
    acc(SPACE_MEM, 0, 16'h3002, 0, 8'h00);
    for (int i = 0; i < 14; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom());
      acc(SPACE_MEM, 1, 16'h3001, v, 0);
      acc(SPACE_MEM, 0, 16'h3001, 0, v & 8'h1f);
      expT = texp(v);
      chk("timing", expT, timing);
      chk("policy", v[4], pageClosePolicy);
      cmd(CMD_ACT);
      cmd(CMD_RW);
      if (!v[4]) cmd(CMD_PRE);
      cmd(CMD_REF);
      cmd(CMD_ACT);
      cmd(CMD_PRE);
      cmdValid = 0;
      repeat (3) @(negedge sys_clk);
      chk("rwgap", expT.rcd, rwGap);
      chk("autopre", v[4], rwAuto);
    end
    chk("spacing", 0, violations);
    finish_test;
  end
endmodule
`default_nettype wire
